// *** core/mpc_defs.svh ***
// Offsets, field positions, reset values and codes of the motor peripheral configuration block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef MPC_DEFS_SVH
`define MPC_DEFS_SVH

// Register indices; byte address is four times the index.
`define MPC_CFG_INDEX 12'h0aa
`define MPC_STAT_INDEX 12'h0ab
`define MPC_CFG_ADDR 12'h2a8
`define MPC_STAT_ADDR 12'h2ac

`define MPC_CFG_RESET 32'h4000_0000
`define MPC_CFG_WMASK 32'h43fd_fe00

`define MPC_DITHER_DIS_BIT 30
`define MPC_ILIM_HI 25
`define MPC_ILIM_LO 22
`define MPC_ILIM_EN_BIT 21
`define MPC_DIRSRC_HI 20
`define MPC_DIRSRC_LO 19
`define MPC_DIRMODE_BIT 18
`define MPC_GAP_HI 16
`define MPC_GAP_LO 13
`define MPC_MOD_HI 12
`define MPC_MOD_LO 10
`define MPC_RANGE_BIT 9

// Highest legal current limit code; codes above it are reserved.
`define MPC_ILIM_MAX_CODE 4'hd
// Last speed gap code on the 5 percent grid.
`define MPC_GAP_FINE_LAST 4'ha

`endif

// *** core/mpc_pkg.sv ***
// Types shared by the motor peripheral configuration block.
// Assumes mpc_defs.svh carries all numeric constants.
package mpc_pkg;

  typedef enum logic [1:0] {
    MPC_DIR_PIN0 = 2'b00,
    MPC_DIR_CW = 2'b01,
    MPC_DIR_CCW = 2'b10,
    MPC_DIR_PIN3 = 2'b11
  } mpc_dir_src_e;

  typedef struct packed {
    logic ditherDisable;
    logic [3:0] currentLimitCode;
    logic currentLimitEnable;
    mpc_dir_src_e dirSource;
    logic dirChangeReverse;
    logic [3:0] brakeSpeedGapCode;
    logic [2:0] brakeModulationCode;
    logic lowSpeedRange;
  } mpc_cfg_s;

  typedef struct packed {
    logic clockDither;
    logic currentLimitActive;
    logic [5:0] currentLimitSteps;
    logic dirCcw;
    logic [6:0] brakeSpeedGapThresh;
    logic [6:0] brakeModulationThresh;
    logic brakeAllowed;
    logic lowSpeedRange;
    logic reservedCode;
  } mpc_ctl_s;

endpackage : mpc_pkg

// *** core/mpc_cfg_decode.sv ***
// Turns the configuration fields into control values for the motor core.
// Assumes its inputs share clk; the direction pin arrives already synchronised.
`timescale 1ns/1ps
`include "mpc_defs.svh"

module mpc_cfg_decode (
  input wire logic clk,
  input wire logic rst,
  input mpc_pkg::mpc_cfg_s cfg,
  input wire logic dirPinSync,
  input wire logic [6:0] speedGapPct,
  input wire logic [6:0] modIndexPct,
  output mpc_pkg::mpc_ctl_s ctl
);

  // Current limit in steps of 0.078125 A: codes 0 and 1 give 1 and 2, then 4 per code.
  function automatic logic [5:0] ilimSteps(input logic [3:0] code);
    logic [5:0] steps;
    steps = 6'h00;
    if (code == 4'h0) begin
      steps = 6'h01;
    end else if (code == 4'h1) begin
      steps = 6'h02;
    end else begin
      steps = {code - 4'h1, 2'b00};
    end
    return steps;
  endfunction : ilimSteps

  // Code 0 is reserved and yields 0, which never lets braking start.
  function automatic logic [6:0] gapPct(input logic [3:0] code);
    logic [6:0] pct;
    pct = 7'h00;
    if (code <= `MPC_GAP_FINE_LAST) begin
      pct = 7'(code) * 7'h05;
    end else begin
      pct = (7'(code) - 7'h05) * 7'h0a;
    end
    return pct;
  endfunction : gapPct

  function automatic logic [6:0] modPct(input logic [2:0] code);
    logic [6:0] pct;
    pct = 7'h00;
    if (code != 3'h0) begin
      pct = 7'h1e + 7'(code) * 7'h0a;
    end
    return pct;
  endfunction : modPct

  wire logic ilimLegal = cfg.currentLimitCode <= `MPC_ILIM_MAX_CODE;
  wire logic [6:0] gapThresh = gapPct(cfg.brakeSpeedGapCode);
  wire logic [6:0] modThresh = modPct(cfg.brakeModulationCode);
  wire logic dirFromPin = (cfg.dirSource == mpc_pkg::MPC_DIR_PIN0) || (cfg.dirSource == mpc_pkg::MPC_DIR_PIN3);
  wire logic dirCcwNxt = dirFromPin ? dirPinSync : (cfg.dirSource == mpc_pkg::MPC_DIR_CCW);
  wire logic brakeNxt = (speedGapPct < gapThresh) && (modIndexPct < modThresh);
  mpc_pkg::mpc_ctl_s ctl_r;
  mpc_pkg::mpc_ctl_s ctl_nxt;

  always_comb begin
    ctl_nxt.clockDither = ~cfg.ditherDisable;
    // Reserved limit codes disable limiting rather than guessing a value.
    ctl_nxt.currentLimitActive = cfg.currentLimitEnable && ilimLegal;
    ctl_nxt.currentLimitSteps = ilimSteps(cfg.currentLimitCode);
    ctl_nxt.dirCcw = dirCcwNxt;
    ctl_nxt.brakeSpeedGapThresh = gapThresh;
    ctl_nxt.brakeModulationThresh = modThresh;
    ctl_nxt.brakeAllowed = brakeNxt;
    ctl_nxt.lowSpeedRange = cfg.lowSpeedRange;
    ctl_nxt.reservedCode = ~ilimLegal || (cfg.brakeSpeedGapCode == 4'h0);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r <= '0;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  assign ctl = ctl_r;

endmodule : mpc_cfg_decode

// *** core/mpc_periph_cfg.sv ***
// Peripheral configuration register of the motor controller with its APB slave.
// Assumes an APB master on clk; the direction pin is asynchronous to clk.
`timescale 1ns/1ps
`include "mpc_defs.svh"

// Notes on behaviour
// - Bit 30 set disables clock dithering; it resets to one.
// - Bit 21 enables bus current limit at the level coded in bits 25-22.
// - Bits 20-19 pick direction: pin, forced clockwise, or forced counter-clockwise.
// - Bit 18 picks stop plus speed detect, or reverse drive, on direction change.
// - Braking only when speed gap is below threshold from bits 16-13.
// - Braking only when modulation index is below limit from bits 12-10.
// - Bit 9 selects low or high frequency range of duty speed input.
module mpc_periph_cfg #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dirPin,
  input wire logic [6:0] speedGapPct,
  input wire logic [6:0] modIndexPct,
  output logic clockDither,
  output logic currentLimitActive,
  output logic [5:0] currentLimitSteps,
  output logic dirCcw,
  output logic [6:0] brakeSpeedGapThresh,
  output logic [6:0] brakeModulationThresh,
  output logic brakeAllowed,
  output logic lowSpeedRange,
  output logic dirChangeStopStart,
  output logic dirChangeReverseStart
);

  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic dirMeta_r;
  logic dirSync_r;
  logic dirCcwPrev_r;
  logic armed_r;
  logic stopPulse_r;
  logic revPulse_r;
  mpc_pkg::mpc_cfg_s cfgFields;
  mpc_pkg::mpc_ctl_s ctl;

  // Bus decode. The slave never stalls, so every access ends in its first access cycle.
  wire logic setup = psel && !penable;
  wire logic access = psel && penable;
  wire logic [ADDR_W-1:0] cfgAddr = ADDR_W'(`MPC_CFG_ADDR);
  wire logic [ADDR_W-1:0] statAddr = ADDR_W'(`MPC_STAT_ADDR);
  wire logic hitCfg = paddr == cfgAddr;
  wire logic hitStat = paddr == statAddr;
  wire logic hitAny = hitCfg || hitStat;
  wire logic cfgWrite = access && pwrite && hitCfg;
  wire logic [31:0] laneMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire logic [31:0] wrMask = laneMask & `MPC_CFG_WMASK;

  // Status word: block state visible to software.
  wire logic [31:0] statusWord = {9'h000, ctl.brakeModulationThresh, 1'b0, ctl.brakeSpeedGapThresh,
    ctl.reservedCode, ctl.brakeAllowed, ctl.dirCcw, ctl.currentLimitActive, ctl.clockDither,
    ctl.lowSpeedRange, armed_r, 1'b0};

  always_comb begin
    cfg_nxt = cfg_r;
    if (cfgWrite) begin
      cfg_nxt = (cfg_r & ~wrMask) | (pwdata & wrMask);
    end
  end

  always_comb begin
    prdata_nxt = prdata_r;
    if (setup && !pwrite) begin
      prdata_nxt = 32'h0000_0000;
      if (hitCfg) begin
        prdata_nxt = cfg_r & `MPC_CFG_WMASK;
      end else if (hitStat) begin
        prdata_nxt = statusWord;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= `MPC_CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      if (setup) begin
        pslverr_r <= !hitAny || (pwrite && hitStat);
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = pslverr_r && access;

  // Field view of the stored word.
  assign cfgFields.ditherDisable = cfg_r[`MPC_DITHER_DIS_BIT];
  assign cfgFields.currentLimitCode = cfg_r[`MPC_ILIM_HI:`MPC_ILIM_LO];
  assign cfgFields.currentLimitEnable = cfg_r[`MPC_ILIM_EN_BIT];
  assign cfgFields.dirSource = mpc_pkg::mpc_dir_src_e'(cfg_r[`MPC_DIRSRC_HI:`MPC_DIRSRC_LO]);
  assign cfgFields.dirChangeReverse = cfg_r[`MPC_DIRMODE_BIT];
  assign cfgFields.brakeSpeedGapCode = cfg_r[`MPC_GAP_HI:`MPC_GAP_LO];
  assign cfgFields.brakeModulationCode = cfg_r[`MPC_MOD_HI:`MPC_MOD_LO];
  assign cfgFields.lowSpeedRange = cfg_r[`MPC_RANGE_BIT];

  // The pin is asynchronous; only the second stage is read by logic.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dirMeta_r <= 1'b0;
      dirSync_r <= 1'b0;
    end else begin
      dirMeta_r <= dirPin;
      dirSync_r <= dirMeta_r;
    end
  end

  mpc_cfg_decode u_decode (
    .clk(clk),
    .rst(rst),
    .cfg(cfgFields),
    .dirPinSync(dirSync_r),
    .speedGapPct(speedGapPct),
    .modIndexPct(modIndexPct),
    .ctl(ctl)
  );

  // A change of the effective direction starts one of two sequences in the motor core.
  // The first cycle after reset only captures the reset value of ctl.dirCcw, so a pin high at reset still gives a start pulse on the fourth edge.
  wire logic dirChanged = armed_r && (ctl.dirCcw != dirCcwPrev_r);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dirCcwPrev_r <= 1'b0;
      armed_r <= 1'b0;
      stopPulse_r <= 1'b0;
      revPulse_r <= 1'b0;
    end else begin
      dirCcwPrev_r <= ctl.dirCcw;
      armed_r <= 1'b1;
      stopPulse_r <= dirChanged && !cfgFields.dirChangeReverse;
      revPulse_r <= dirChanged && cfgFields.dirChangeReverse;
    end
  end

  assign clockDither = ctl.clockDither;
  assign currentLimitActive = ctl.currentLimitActive;
  assign currentLimitSteps = ctl.currentLimitSteps;
  assign dirCcw = ctl.dirCcw;
  assign brakeSpeedGapThresh = ctl.brakeSpeedGapThresh;
  assign brakeModulationThresh = ctl.brakeModulationThresh;
  assign brakeAllowed = ctl.brakeAllowed;
  assign lowSpeedRange = ctl.lowSpeedRange;
  assign dirChangeStopStart = stopPulse_r;
  assign dirChangeReverseStart = revPulse_r;

endmodule : mpc_periph_cfg

// *** sim/mpc_periph_cfg_asserts.sv ***
// Port-level checks of the motor peripheral configuration block.
// Assumes it is bound to mpc_periph_cfg and sees only its ports.
`timescale 1ns/1ps
`include "mpc_defs.svh"
module mpc_periph_cfg_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [6:0] speedGapPct,
  input wire logic [6:0] modIndexPct,
  input wire logic clockDither,
  input wire logic currentLimitActive,
  input wire logic dirCcw,
  input wire logic [6:0] brakeSpeedGapThresh,
  input wire logic [6:0] brakeModulationThresh,
  input wire logic brakeAllowed,
  input wire logic lowSpeedRange,
  input wire logic dirChangeStopStart,
  input wire logic dirChangeReverseStart
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire wrCfg = acc && pwrite && paddr == `MPC_CFG_ADDR && pstrb == 4'hf;
  AST_ERR_IN_ACCESS: assert property (pslverr |-> acc && pready) else $error("error outside access");
  AST_DITHER: assert property (wrCfg |-> ##2 clockDither == !$past(pwdata[30], 2))
    else $error("dither state wrong");
  AST_LIMIT: assert property (wrCfg |-> ##2 currentLimitActive ==
    ($past(pwdata[21], 2) && $past(pwdata[25:22], 2) <= 4'hd)) else $error("limit enable wrong");
  AST_DIR_FORCED: assert property (wrCfg && pwdata[20] != pwdata[19] |-> ##2 dirCcw == $past(pwdata[20], 2))
    else $error("forced direction wrong");
  AST_RANGE: assert property (wrCfg |-> ##2 lowSpeedRange == $past(pwdata[9], 2))
    else $error("speed range wrong");
  AST_BRAKE: assert property (($stable(brakeSpeedGapThresh) && $stable(brakeModulationThresh)) ##1
    ($stable(brakeSpeedGapThresh) && $stable(brakeModulationThresh)) |-> brakeAllowed ==
    ($past(speedGapPct) < $past(brakeSpeedGapThresh) && $past(modIndexPct) < $past(brakeModulationThresh)))
    else $error("brake permission wrong");
  AST_RSVD_READ: assert property (acc && !pwrite && paddr == `MPC_CFG_ADDR |->
    (prdata & ~`MPC_CFG_WMASK) == 32'h0) else $error("reserved bit reads one");
  AST_UNMAPPED: assert property (acc && paddr != `MPC_CFG_ADDR && paddr != `MPC_STAT_ADDR |->
    pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access accepted");
  AST_DIR_PULSE: assert property ($changed(dirCcw) |=> dirChangeStopStart != dirChangeReverseStart)
    else $error("direction change not announced");
endmodule : mpc_periph_cfg_asserts

bind mpc_periph_cfg mpc_periph_cfg_asserts #(.ADDR_W(ADDR_W)) mpc_periph_cfg_asserts_inst (.clk, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .speedGapPct, .modIndexPct,
  .clockDither, .currentLimitActive, .dirCcw, .brakeSpeedGapThresh, .brakeModulationThresh, .brakeAllowed,
  .lowSpeedRange, .dirChangeStopStart, .dirChangeReverseStart);

// *** sim/mpc_periph_cfg_test.sv ***
// Self-checking bench for the motor peripheral configuration block.
// Assumes the design and its checker are compiled before it.
`timescale 1ns/1ps
`include "mpc_defs.svh"
module mpc_periph_cfg_test;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, dirPin = 0, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, q, prdata;
  logic [3:0] pstrb = 4'h0;
  logic [6:0] speedGapPct = 7'h0, modIndexPct = 7'h0, brakeSpeedGapThresh, brakeModulationThresh;
  logic [5:0] currentLimitSteps;
  logic pready, pslverr, clockDither, currentLimitActive, dirCcw, brakeAllowed, lowSpeedRange;
  logic dirChangeStopStart, dirChangeReverseStart;
  int nErrors = 0, checksDone = 0, nStop = 0, nRev = 0;
  mpc_periph_cfg mpc_periph_cfg_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .dirPin, .speedGapPct, .modIndexPct, .clockDither, .currentLimitActive,
    .currentLimitSteps, .dirCcw, .brakeSpeedGapThresh, .brakeModulationThresh, .brakeAllowed,
    .lowSpeedRange, .dirChangeStopStart, .dirChangeReverseStart);
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    nStop += int'(dirChangeStopStart === 1'b1);
    nRev += int'(dirChangeReverseStart === 1'b1);
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // The request holds until pready is seen high at a rising edge; the answer is taken at that same edge.
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    chk(n < 50, 1'b1);
    psel <= 0; penable <= 0;
  endtask : xfer
  task wcfg(input logic [31:0] d);
    xfer(1, `MPC_CFG_ADDR, d, 4'hf);
    repeat (5) @(negedge clk);
  endtask : wcfg
  function automatic logic [6:0] gapExp(input int c);
    return c == 0 ? 7'h0 : c <= 10 ? 7'(5 * c) : 7'(10 * (c - 5));
  endfunction : gapExp
  task giveVerdict;
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : giveVerdict
  initial begin
    #100000;
    nErrors++;
    giveVerdict;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    xfer(0, `MPC_CFG_ADDR, 0, 0);
    chk(q, 32'h4000_0000);
    chk(clockDither, 1'b0);
    $display("test reset done");
    wcfg(32'hffff_ffff);
    xfer(0, `MPC_CFG_ADDR, 0, 0);
    chk(q, 32'h43fd_fe00);
    chk(lowSpeedRange, 1'b1);
    chk(dirCcw, 1'b0);
    xfer(1, `MPC_CFG_ADDR, 32'h0, 4'h8);
    xfer(0, `MPC_CFG_ADDR, 0, 0);
    chk(q, 32'h00fd_fe00);
    $display("test reserved done");
    for (int i = 0; i < 16; i++) begin
      wcfg(32'h0020_0000 | i << 22 | i << 13 | (i & 7) << 10);
      chk(clockDither, 1'b1);
      chk(lowSpeedRange, 1'b0);
      chk(currentLimitActive, i <= 13);
      if (i <= 13) chk(currentLimitSteps, i == 0 ? 1 : i == 1 ? 2 : 4 * (i - 1));
      chk(brakeSpeedGapThresh, gapExp(i));
      chk(brakeModulationThresh, (i & 7) == 0 ? 0 : 30 + 10 * (i & 7));
    end
    wcfg(32'h0140_0000);
    chk(currentLimitActive, 1'b0);
    $display("test codes done");
    wcfg(32'h0000_4400);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      speedGapPct <= k == 1 ? 7'ha : 7'h9;
      modIndexPct <= k == 2 ? 7'h28 : 7'h27;
      repeat (3) @(negedge clk);
      chk(brakeAllowed, k == 0);
    end
    $display("test brake done");
    @(posedge clk);
    dirPin <= 1;
    repeat (8) @(negedge clk);
    chk(dirCcw, 1'b1);
    chk(nStop, 1);
    wcfg(32'h000c_0000);
    chk(dirCcw, 1'b0);
    chk(nRev, 1);
    wcfg(32'h0010_0000);
    chk(dirCcw, 1'b1);
    chk(nStop, 2);
    wcfg(32'h000c_0000);
    chk(nRev, 2);
    wcfg(32'h001c_0000);
    chk(dirCcw, 1'b1);
    chk(nRev, 3);
    $display("test direction done");
    xfer(0, 12'h100, 0, 0);
    chk(err, 1'b1);
    chk(q, 32'h0000_0000);
    xfer(1, `MPC_STAT_ADDR, 32'hffff_ffff, 4'hf);
    chk(err, 1'b1);
    xfer(0, `MPC_CFG_ADDR, 0, 0);
    chk(q, 32'h001c_0000);
    xfer(0, `MPC_STAT_ADDR, 0, 0);
    chk(err, 1'b0);
    chk(q, 32'h0000_00aa);
    $display("test refusal done");
    giveVerdict;
  end
endmodule : mpc_periph_cfg_test
